//--- verilog/afw_defs.vh
// Purpose: shared codes and limits for the ascii frame responder
// Assumes: byte-wide link, ascii framing
// Notes: definitions only
`ifndef AFW_DEFS_VH
`define AFW_DEFS_VH
`define AFW_ENQ 8'h05
`define AFW_EOT 8'h04
`define AFW_ACK 8'h06
`define AFW_NAK 8'h15
`define AFW_ETX 8'h03
`define AFW_CMD_W 8'h57
`define AFW_CMD_X 8'h58
`define AFW_CH_S 8'h53
`define AFW_CH_B 8'h42
`define AFW_CH_R 8'h52
`define AFW_CH_0 8'h30
`define AFW_CH_9 8'h39
`define AFW_CH_PCT 8'h25
`define AFW_LOWER_BIT 5
`define AFW_NAME_MIN 8'h01
`define AFW_NAME_MAX 8'h10
`define AFW_ITEM_MAX 8'hf0
`define AFW_SLOTS 10
`define AFW_SLOT_MAX 4'h9
`define AFW_ERR_TYPE 16'h0101
`define AFW_ERR_BCC 16'h0102
`define AFW_ERR_SLOT 16'h0103
`define AFW_ERR_FMT 16'h0104
`define AFW_ERR_NAME 16'h0105
`define AFW_ERR_COUNT 16'h0106
`define AFW_ERR_LONG 16'h0107
`endif

//--- verilog/afw_frame_block.v
// Purpose: slave ascii frame handler, block write replies and monitor slots
// Assumes: byte stream from a same-clock transport, host is the master
// Notes: replies drain through an 8-word fifo; memory write is external
//
// Operation
// - clean block write answers ack, station, command, type, etx
// - failed block write answers nak with four-character error code
// - error code is two bytes sent as four ascii hex characters
// - lowercase command adds sum check to a positive reply
// - lowercase command adds sum check to a negative reply
// - ten slots numbered 00 to 09; others never stored
// - registering an occupied slot overwrites it
// - stored registrations stay readable until a rejected registration to the same slot clears them
// - individual description starts with its individual tag
// - continuous description starts with its continuous tag
// - accepted registration answers ack with echoed slot number
// - rejected registration answers nak with slot and error code
// - block write item count at most 240
// - name length 01 to 10 hex; digits, letters, percent
// - data is ascii hex, most significant digit first
`include "afw_defs.vh"
`timescale 1ns/1ps
`default_nettype none

// ========================================
// reply fifo
module afw_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output wire inReady,
    output reg [WIDTH-1:0] outData,
    output reg outValid,
    input wire outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    reg [AW:0] count;
    wire push = inValid && inReady;
    wire pop = (|count) && (!outValid || outReady);
    assign inReady = (count != DEPTH[AW:0]);
    always @(posedge clk) begin
        if (ce && push) begin
            mem[wrPtr] <= inData;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            outData <= {WIDTH{1'b0}};
            outValid <= 1'b0;
        end else if (ce) begin
            if (push) wrPtr <= wrPtr + 1'b1;
            if (pop) begin
                rdPtr <= rdPtr + 1'b1;
                outData <= mem[rdPtr];
                outValid <= 1'b1;
            end else if (outReady) begin
                outValid <= 1'b0;
            end
            if (push && !pop) count <= count + 1'b1;
            else if (pop && !push) count <= count - 1'b1;
        end
    end
endmodule

// ========================================
// frame handler
module afw_frame_block #(
    parameter SLOT_BYTES = 293
) (
    input wire clk,
    input wire reset_n,
    input wire ce,
    input wire [7:0] stationId,
    input wire [7:0] rxData,
    input wire rxValid,
    output reg rxReady,
    output wire [7:0] txData,
    output wire txValid,
    input wire txReady,
    output reg [7:0] bodyByte,
    output reg bodyValid,
    output reg blkWriteReq,
    input wire blkWriteDone,
    input wire blkWriteErr,
    input wire [15:0] blkWriteCode,
    input wire [3:0] slotRdSel,
    input wire [8:0] slotRdAddr,
    output reg [7:0] slotRdData,
    output reg [8:0] slotRdLen,
    output reg slotRdValid
);
    localparam S_IDLE = 4'd0, S_ST1 = 4'd1, S_ST2 = 4'd2, S_CMD = 4'd3;
    localparam S_F1 = 4'd4, S_F2 = 4'd5, S_BODY = 4'd6, S_BCC1 = 4'd7;
    localparam S_BCC2 = 4'd8, S_DONE = 4'd9, S_EXEC = 4'd10;
    localparam S_REPLY = 4'd11;

    function [7:0] hexChar;
        input [3:0] n;
        hexChar = (n < 4'ha) ? {4'h3, n} : (8'h37 + {4'h0, n});
    endfunction
    function [3:0] hexVal;
        input [7:0] c;
        hexVal = (c <= `AFW_CH_9) ? c[3:0] : (c[3:0] + 4'h9);
    endfunction
    function nameOk;
        input [7:0] c;
        nameOk = (c >= `AFW_CH_0 && c <= `AFW_CH_9) ||
                 (c >= 8'h41 && c <= 8'h5a) ||
                 (c >= 8'h61 && c <= 8'h7a) || (c == `AFW_CH_PCT);
    endfunction

    reg rstMeta, rstSync;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    reg [7:0] slotMem [0:`AFW_SLOTS*SLOT_BYTES-1];
    reg [8:0] slotLen [0:`AFW_SLOTS-1];
    reg [`AFW_SLOTS-1:0] slotValid;

    reg [3:0] state;
    reg [7:0] cmd, fld1, fld2, hiChar, rxSum, txSum, nameLen;
    reg [15:0] errCode;
    reg isErr, isNak;
    reg [8:0] bodyCnt;
    reg [3:0] step;
    reg [3:0] slot;
    reg [7:0] txByte;
    wire fifoReady;
    wire take = rxValid && rxReady;
    wire isLower = cmd[`AFW_LOWER_BIT];
    wire [7:0] cmdUp = cmd & 8'hdf;
    wire regOk = (cmdUp == `AFW_CMD_X) && !isErr;
    wire [7:0] pairVal = {hexVal(hiChar), hexVal(rxData)};
    wire lenBad = pairVal < `AFW_NAME_MIN || pairVal > `AFW_NAME_MAX;
    wire pushTx = (state == S_REPLY) && fifoReady;
    wire [11:0] slotBase = slot * SLOT_BYTES[11:0];
    wire [11:0] rdBase = slotRdSel * SLOT_BYTES[11:0];

    always @* begin
        case (step)
            4'd0: txByte = isNak ? `AFW_NAK : `AFW_ACK;
            4'd1: txByte = hexChar(stationId[7:4]);
            4'd2: txByte = hexChar(stationId[3:0]);
            4'd3: txByte = cmd;
            4'd4: txByte = fld1;
            4'd5: txByte = fld2;
            4'd6: txByte = hexChar(errCode[15:12]);
            4'd7: txByte = hexChar(errCode[11:8]);
            4'd8: txByte = hexChar(errCode[7:4]);
            4'd9: txByte = hexChar(errCode[3:0]);
            4'd10: txByte = `AFW_ETX;
            4'd11: txByte = hexChar(txSum[7:4]);
            4'd12: txByte = hexChar(txSum[3:0]);
            default: txByte = 8'h00;
        endcase
    end

    afw_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) u_fifo (
        .clk(clk),
        .rst_n(rstSync),
        .ce(ce),
        .inData(txByte),
        .inValid(pushTx),
        .inReady(fifoReady),
        .outData(txData),
        .outValid(txValid),
        .outReady(txReady)
    );

    // ========================================
    // slot storage and read-back
    always @(posedge clk) begin
        if (ce && take && state == S_BODY && regOk &&
            rxData != `AFW_EOT && bodyCnt < SLOT_BYTES) begin
            slotMem[slotBase + {3'h0, bodyCnt}] <= rxData;
        end
        if (ce && state == S_DONE && regOk) begin
            slotLen[slot] <= bodyCnt;
        end
    end

    always @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            slotRdData <= 8'h00;
            slotRdLen <= 9'h000;
            slotRdValid <= 1'b0;
        end else if (ce) begin
            // out-of-range selects read as empty
            slotRdValid <= (slotRdSel <= `AFW_SLOT_MAX) &&
                           slotValid[slotRdSel];
            slotRdLen <= (slotRdSel <= `AFW_SLOT_MAX) ?
                         slotLen[slotRdSel] : 9'h000;
            slotRdData <= (slotRdSel <= `AFW_SLOT_MAX &&
                           slotRdAddr < SLOT_BYTES) ?
                          slotMem[rdBase + {3'h0, slotRdAddr}] : 8'h00;
        end
    end

    // ========================================
    // receive parser and reply sequencer
    always @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            state <= S_IDLE;
            rxReady <= 1'b0;
            cmd <= 8'h00;
            fld1 <= 8'h00;
            fld2 <= 8'h00;
            hiChar <= 8'h00;
            rxSum <= 8'h00;
            txSum <= 8'h00;
            nameLen <= 8'h00;
            errCode <= 16'h0000;
            isErr <= 1'b0;
            isNak <= 1'b0;
            bodyCnt <= 9'h000;
            step <= 4'd0;
            slot <= 4'h0;
            slotValid <= {`AFW_SLOTS{1'b0}};
            bodyByte <= 8'h00;
            bodyValid <= 1'b0;
            blkWriteReq <= 1'b0;
        end else if (ce) begin
            bodyValid <= 1'b0;
            blkWriteReq <= 1'b0;
            if (state == S_IDLE) rxReady <= 1'b1;
            if (take && state < S_BCC1) rxSum <= rxSum + rxData;
            case (state)
                S_IDLE: begin
                    if (take && rxData == `AFW_ENQ) begin
                        rxSum <= rxData;
                        isErr <= 1'b0;
                        errCode <= 16'h0000;
                        bodyCnt <= 9'h000;
                        state <= S_ST1;
                    end
                end
                S_ST1: begin
                    if (take) begin
                        hiChar <= rxData;
                        state <= S_ST2;
                    end
                end
                S_ST2: begin
                    if (take) begin
                        // foreign station: drop silently
                        if (pairVal != stationId)
                            state <= S_IDLE;
                        else
                            state <= S_CMD;
                    end
                end
                S_CMD: begin
                    if (take) begin
                        cmd <= rxData;
                        if ((rxData & 8'hdf) == `AFW_CMD_W ||
                            (rxData & 8'hdf) == `AFW_CMD_X)
                            state <= S_F1;
                        else
                            state <= S_IDLE;
                    end
                end
                S_F1: begin
                    if (take) begin
                        fld1 <= rxData;
                        state <= S_F2;
                    end
                end
                S_F2: begin
                    if (take) begin
                        fld2 <= rxData;
                        state <= S_BODY;
                        if (cmdUp == `AFW_CMD_W) begin
                            if (fld1 != `AFW_CH_S || rxData != `AFW_CH_B) begin
                                isErr <= 1'b1;
                                errCode <= `AFW_ERR_TYPE;
                            end
                        end else begin
                            slot <= hexVal(rxData);
                            if (fld1 != `AFW_CH_0 || rxData < `AFW_CH_0 ||
                                rxData > `AFW_CH_9) begin
                                isErr <= 1'b1;
                                errCode <= `AFW_ERR_SLOT;
                            end
                        end
                    end
                end
                S_BODY: begin
                    if (take && rxData == `AFW_EOT) begin
                        state <= isLower ? S_BCC1 : S_DONE;
                        if (regOk && bodyCnt < 9'd3) begin
                            isErr <= 1'b1;
                            errCode <= `AFW_ERR_FMT;
                        end
                    end else if (take) begin
                        bodyCnt <= bodyCnt + 1'b1;
                        if (cmdUp == `AFW_CMD_W && !isErr) begin
                            bodyByte <= rxData;
                            bodyValid <= 1'b1;
                            if (bodyCnt == 9'd0) hiChar <= rxData;
                            if (bodyCnt == 9'd1) nameLen <= pairVal;
                            if ((bodyCnt == 9'd1 && lenBad) ||
                                (bodyCnt > 9'd1 && !nameOk(rxData) &&
                                 bodyCnt < {1'b0, nameLen} + 9'd2)) begin
                                isErr <= 1'b1;
                                errCode <= `AFW_ERR_NAME;
                            end
                            if (bodyCnt == {1'b0, nameLen} + 9'd2)
                                hiChar <= rxData;
                            if (bodyCnt == {1'b0, nameLen} + 9'd3 &&
                                pairVal > `AFW_ITEM_MAX) begin
                                isErr <= 1'b1;
                                errCode <= `AFW_ERR_COUNT;
                            end
                        end
                        if (regOk) begin
                            if ((bodyCnt == 9'd0 && rxData != `AFW_CH_R) ||
                                (bodyCnt == 9'd1 && rxData != `AFW_CH_S) ||
                                (bodyCnt == 9'd2 && rxData != `AFW_CH_S &&
                                 rxData != `AFW_CH_B)) begin
                                isErr <= 1'b1;
                                errCode <= `AFW_ERR_FMT;
                            end
                            if (bodyCnt >= SLOT_BYTES) begin
                                isErr <= 1'b1;
                                errCode <= `AFW_ERR_LONG;
                            end
                        end
                    end
                end
                S_BCC1: begin
                    if (take) begin
                        hiChar <= rxData;
                        state <= S_BCC2;
                    end
                end
                S_BCC2: begin
                    if (take) begin
                        state <= S_DONE;
                        if (pairVal != rxSum &&
                            !isErr) begin
                            isErr <= 1'b1;
                            errCode <= `AFW_ERR_BCC;
                        end
                    end
                end
                S_DONE: begin
                    rxReady <= 1'b0;
                    step <= 4'd0;
                    txSum <= 8'h00;
                    isNak <= isErr;
                    if (cmdUp == `AFW_CMD_X && isErr && errCode != `AFW_ERR_SLOT)
                        slotValid[slot] <= 1'b0;
                    if (regOk)
                        slotValid[slot] <= 1'b1;
                    if (cmdUp == `AFW_CMD_W && !isErr) begin
                        blkWriteReq <= 1'b1;
                        state <= S_EXEC;
                    end else begin
                        state <= S_REPLY;
                    end
                end
                S_EXEC: begin
                    if (blkWriteDone) begin
                        isNak <= blkWriteErr;
                        errCode <= blkWriteCode;
                        state <= S_REPLY;
                    end
                end
                S_REPLY: begin
                    if (pushTx) begin
                        if (step <= 4'd10) txSum <= txSum + txByte;
                        if (step == 4'd5 && !isNak)
                            step <= 4'd10;
                        else if ((step == 4'd10 && !isLower) || step == 4'd12)
                            state <= S_IDLE;
                        else
                            step <= step + 1'b1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- test/afw_frame_block_monitor.sv
// Purpose: port checks for the ascii frame handler
// Assumes: one clock, reset_n async active low
// Notes: attached by bind below
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checker
module afw_frame_block_monitor #(
    parameter SLOT_BYTES = 293
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [7:0] bodyByte,
    input wire logic bodyValid,
    input wire logic blkWriteReq,
    input wire logic blkWriteDone,
    input wire logic [3:0] slotRdSel,
    input wire logic [8:0] slotRdLen,
    input wire logic slotRdValid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_rx_closed;
        !rxReady ##1 !rxReady;
    endsequence
    sequence s_reply_starts;
        ##[1:20] txValid;
    endsequence
    a_reset_quiet:
        assert property ($rose(reset_n) |-> !txValid && !blkWriteReq ##1 !rxReady)
        else $error("active after reset");
    a_tx_hold:
        assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("tx byte moved");
    a_req_pulse:
        assert property (blkWriteReq && ce |=> !blkWriteReq)
        else $error("long write request");
    a_req_rx_closed:
        assert property (blkWriteReq |-> s_rx_closed)
        else $error("rx open in write");
    a_req_waits:
        assert property (blkWriteReq |=> (!txValid)[*3])
        else $error("early reply");
    a_done_reply:
        assert property (blkWriteDone |-> s_reply_starts)
        else $error("no reply");
    a_slot_range:
        assert property (slotRdSel > 4'h9 |=> !slotRdValid)
        else $error("slot above nine reads as valid");
    a_slot_len:
        assert property (slotRdValid |-> slotRdLen <= SLOT_BYTES && slotRdLen != 9'h000)
        else $error("bad slot length");
    a_body_rx:
        assert property (bodyValid |-> $past(rxValid) && $past(rxReady) && bodyByte == $past(rxData))
        else $error("body byte differs");
    a_ce_hold:
        assert property (!ce |=> $stable(txValid) && $stable(rxReady))
        else $error("moved while ce low");
endmodule

bind afw_frame_block afw_frame_block_monitor #(.SLOT_BYTES(SLOT_BYTES)) afw_mon (
    .clk(clk), .reset_n(reset_n), .ce(ce), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
    .txValid(txValid), .txReady(txReady), .bodyByte(bodyByte),
    .bodyValid(bodyValid), .blkWriteReq(blkWriteReq),
    .blkWriteDone(blkWriteDone), .slotRdSel(slotRdSel),
    .slotRdLen(slotRdLen), .slotRdValid(slotRdValid)
);
`default_nettype wire

//--- test/afw_host_model.sv
// Purpose: host model that frames requests and sinks replies
// Assumes: signals change 1 ns after the rising edge
// Notes: idle rx line shows the inverse of the last byte
`include "afw_defs.vh"
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host
module afw_host_model (
    input wire logic clk,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady
);
    logic [7:0] body[$];
    logic [7:0] reply[$];
    logic slow = 1'b0;
    initial begin
        rxData = 8'h00;
        rxValid = 1'b0;
        txReady = 1'b1;
    end
    function automatic logic [7:0] hx(input logic [3:0] n);
        hx = (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
    endfunction
    // a byte counts when ready is still high at the coming edge
    always @(negedge clk) begin
        if (txValid && txReady)
            reply.push_back(txData);
    end
    always @(posedge clk) begin
        #1 txReady = slow ? ~txReady : 1'b1;
    end
    task automatic load(input string s);
        foreach (s[i]) body.push_back(s[i]);
    endtask
    task automatic put(input logic [7:0] b);
        rxData = b;
        rxValid = 1'b1;
        @(negedge clk);
        for (int n = 0; n < 1000 && !rxReady; n++) @(negedge clk);
        @(posedge clk);
        #1;
    endtask
    // enq, station, command, fields, body, eot, check
    task automatic frame(input logic [7:0] st, cmd, f1, f2, input logic badSum);
        logic [7:0] q[$];
        logic [7:0] sum;
        @(posedge clk);
        #1;
        q = {`AFW_ENQ, hx(st[7:4]), hx(st[3:0]), cmd, f1, f2};
        foreach (body[i]) q.push_back(body[i]);
        q.push_back(`AFW_EOT);
        sum = {7'h00, badSum};
        foreach (q[i]) sum = sum + q[i];
        if (cmd[`AFW_LOWER_BIT]) begin
            q.push_back(hx(sum[7:4]));
            q.push_back(hx(sum[3:0]));
        end
        foreach (q[i]) put(q[i]);
        rxValid = 1'b0;
        rxData = ~rxData;
        body.delete();
    endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Purpose: self-checking bench for the ascii frame handler
// Assumes: 200 MHz clock, host model on the serial side
// Notes: write completion is played by the bench
`include "afw_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] ST = 8'h01;
    localparam string WB = "06%MW10001AA15";
    logic clk, reset_n, ce, rxValid, rxReady, txValid, txReady;
    logic bodyValid, blkWriteReq, blkWriteDone, blkWriteErr, wrFail;
    logic slotRdValid;
    logic [7:0] rxData, txData, bodyByte, slotRdData;
    logic [15:0] blkWriteCode, wrCode;
    logic [3:0] slotRdSel;
    logic [8:0] slotRdAddr, slotRdLen;
    logic [7:0] bodyQ[$];
    int err_total = 0, checks_done = 0, reqSeen = 0, cycles = 0;
    afw_frame_block afw_frame_block_inst (
        .clk(clk), .reset_n(reset_n), .ce(ce), .stationId(ST),
        .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
        .txData(txData), .txValid(txValid), .txReady(txReady),
        .bodyByte(bodyByte), .bodyValid(bodyValid),
        .blkWriteReq(blkWriteReq), .blkWriteDone(blkWriteDone),
        .blkWriteErr(blkWriteErr), .blkWriteCode(blkWriteCode),
        .slotRdSel(slotRdSel), .slotRdAddr(slotRdAddr),
        .slotRdData(slotRdData), .slotRdLen(slotRdLen),
        .slotRdValid(slotRdValid)
    );
    afw_host_model host (
        .clk(clk), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
        .txData(txData), .txValid(txValid), .txReady(txReady)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================
    // write completion and observers
    always @(negedge clk) begin
        if (bodyValid)
            bodyQ.push_back(bodyByte);
    end
    always @(negedge clk) begin
        if (blkWriteReq) begin
            reqSeen++;
            repeat (3) @(posedge clk);
            #1 blkWriteDone = 1'b1;
            blkWriteErr = wrFail;
            blkWriteCode = wrCode;
            @(posedge clk);
            #1 blkWriteDone = 1'b0;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("BAD %0t run timed out", $time);
            conclude;
        end
    end
    // ==========================================
    // helpers
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic expect_reply(input logic [7:0] hdr, cmd, e1, e2,
                                input logic [15:0] code);
        logic [7:0] q[$];
        logic [7:0] sum;
        q = {hdr, host.hx(ST[7:4]), host.hx(ST[3:0]), cmd, e1, e2};
        if (hdr == `AFW_NAK)
            for (int k = 12; k >= 0; k -= 4) q.push_back(host.hx(code[k+:4]));
        q.push_back(`AFW_ETX);
        sum = 8'h00;
        foreach (q[i]) sum = sum + q[i];
        if (cmd[`AFW_LOWER_BIT]) begin
            q.push_back(host.hx(sum[7:4]));
            q.push_back(host.hx(sum[3:0]));
        end
        for (int n = 0; n < 2000 && host.reply.size() < q.size(); n++)
            @(negedge clk);
        // surplus bytes show up too
        repeat (6) @(negedge clk);
        check(host.reply.size(), q.size(), "reply length");
        foreach (q[i]) if (i < host.reply.size()) check(host.reply[i], q[i], "reply byte");
        host.reply.delete();
    endtask
    task automatic wr(input string s, input logic [7:0] cmd, f2, input logic bad,
                      input logic [7:0] hdr, input logic [15:0] code);
        host.load(s);
        host.frame(ST, cmd, `AFW_CH_S, f2, bad);
        expect_reply(hdr, cmd, `AFW_CH_S, f2, code);
    endtask
    task automatic reg_frame(input logic [7:0] cmd, input string slot, body,
                             input logic [7:0] hdr, input logic [15:0] code);
        host.load(body);
        host.frame(ST, cmd, slot[0], slot[1], 1'b0);
        expect_reply(hdr, cmd, slot[0], slot[1], code);
    endtask
    task automatic slot_read(input logic [3:0] sel, input logic [8:0] addr,
                             input logic v, input logic [7:0] b, input logic [8:0] len);
        @(posedge clk);
        #1 slotRdSel = sel;
        slotRdAddr = addr;
        @(posedge clk);
        @(negedge clk);
        check(slotRdValid, v, "slot valid");
        if (v) begin
            check(slotRdData, b, "slot byte");
            check(slotRdLen, len, "slot length");
        end
    endtask
    // ==========================================
    // scenarios
    task automatic t_foreign;
        host.load(WB);
        host.frame(8'h02, 8'h77, `AFW_CH_S, `AFW_CH_B, 1'b0);
        repeat (40) @(negedge clk);
        check(host.reply.size() + reqSeen, 16'h0, "foreign frame");
        $display("test foreign done");
    endtask
    task automatic t_write_ok;
        bodyQ.delete();
        reqSeen = 0;
        wr(WB, 8'h77, `AFW_CH_B, 1'b0, `AFW_ACK, 16'h0);
        check(reqSeen, 16'h1, "write requests");
        check(bodyQ.size(), 16'he, "body count");
        foreach (bodyQ[i]) check(bodyQ[i], WB[i], "body byte");
        $display("test write_ok done");
    endtask
    task automatic t_write_fail;
        host.slow = 1'b1;
        wrFail = 1'b1;
        wrCode = 16'h1132;
        wr(WB, 8'h57, `AFW_CH_B, 1'b0, `AFW_NAK, 16'h1132);
        wr(WB, 8'h77, `AFW_CH_B, 1'b0, `AFW_NAK, 16'h1132);
        host.slow = 1'b0;
        wrFail = 1'b0;
        $display("test write_fail done");
    endtask
    task automatic t_write_refused;
        reqSeen = 0;
        wr("06%MW#0001AA15", 8'h77, `AFW_CH_B, 1'b0, `AFW_NAK, `AFW_ERR_NAME);
        wr("06%MW100F1AA15", 8'h77, `AFW_CH_B, 1'b0, `AFW_NAK, `AFW_ERR_COUNT);
        wr(WB, 8'h77, `AFW_CH_B, 1'b1, `AFW_NAK, `AFW_ERR_BCC);
        wr(WB, 8'h57, `AFW_CH_S, 1'b0, `AFW_NAK, `AFW_ERR_TYPE);
        check(reqSeen, 16'h0, "refused writes ran");
        $display("test write_refused done");
    endtask
    task automatic t_register;
        reg_frame(8'h78, "03", "RSB06%MW00002", `AFW_ACK, 16'h0000);
        slot_read(4'h3, 9'h002, 1'b1, `AFW_CH_B, 9'h00d);
        reg_frame(8'h58, "03", "RSS0104%MW1", `AFW_ACK, 16'h0000);
        slot_read(4'h3, 9'h002, 1'b1, `AFW_CH_S, 9'h00b);
        reg_frame(8'h78, "09", "RSS0106%MW000", `AFW_ACK, 16'h0000);
        slot_read(4'h9, 9'h00c, 1'b1, `AFW_CH_0, 9'h00d);
        $display("test register done");
    endtask
    task automatic t_reg_refused;
        reg_frame(8'h78, "10", "RSS0106%MW000", `AFW_NAK, `AFW_ERR_SLOT);
        slot_read(4'ha, 9'h000, 1'b0, 8'h00, 9'h000);
        reg_frame(8'h58, "03", "RXX01", `AFW_NAK, `AFW_ERR_FMT);
        slot_read(4'h3, 9'h000, 1'b0, 8'h00, 9'h000);
        slot_read(4'h9, 9'h000, 1'b1, `AFW_CH_R, 9'h00d);
        $display("test reg_refused done");
    endtask
    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        slotRdSel = 4'h0;
        slotRdAddr = 9'h000;
        blkWriteDone = 1'b0;
        blkWriteErr = 1'b0;
        blkWriteCode = 16'h0000;
        wrFail = 1'b0;
        wrCode = 16'h0000;
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 ce = 1'b0;
        repeat (3) @(posedge clk);
        #1 ce = 1'b1;
        t_foreign;
        t_write_ok;
        t_write_fail;
        t_write_refused;
        t_register;
        t_reg_refused;
        conclude;
    end
endmodule
`default_nettype wire
